// ---- trb_result_bank.sv ----
// Reflection diagnostic result register bank with AXI4-Lite slave and interrupt
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

// What this block does
// - Location fields are 8-bit, read-only, reset zero
// - 197h: D location 0 high, C4 low
// - 198h: D location 2 high, D1 low
// - 199h: D location 4 high, D3 low
// - Status resets zero, bits 15-12 zero
// - Status 11..8 flag cross-mode peaks D..A
// - Status 7..4 flag five or more peaks D..A
// - Status 3..0 flag segment-one threshold D..A
// - 1A5h: A/B sign bits, upper zero
module trb_result_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic run_done,
    input wire logic [7:0] peak_position_chan_c_4,
    input wire logic [7:0] peak_position_chan_d_0,
    input wire logic [7:0] peak_position_chan_d_1,
    input wire logic [7:0] peak_position_chan_d_2,
    input wire logic [7:0] peak_position_chan_d_3,
    input wire logic [7:0] peak_position_chan_d_4,
    input wire logic [4:0] peak_polarity_chan_a,
    input wire logic [4:0] peak_polarity_chan_b,
    input wire logic cross_mode_peak_flag_a,
    input wire logic cross_mode_peak_flag_b,
    input wire logic cross_mode_peak_flag_c,
    input wire logic cross_mode_peak_flag_d,
    input wire logic [2:0] peak_total_a,
    input wire logic [2:0] peak_total_b,
    input wire logic [2:0] peak_total_c,
    input wire logic [2:0] peak_total_d,
    input wire logic first_segment_high_cross_a,
    input wire logic first_segment_high_cross_b,
    input wire logic first_segment_high_cross_c,
    input wire logic first_segment_high_cross_d,
    output logic irq
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Word address decode, shared by read and write paths
    function automatic trb_pkg::trb_sel_t decode(input logic [11:0] addr);
        trb_pkg::trb_sel_t sel;
        sel = trb_pkg::SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr[11:2] == trb_pkg::IDX_LOC_C4_D0) begin
                sel = trb_pkg::SEL_LOC0;
            end else if (addr[11:2] == trb_pkg::IDX_LOC_D1_D2) begin
                sel = trb_pkg::SEL_LOC1;
            end else if (addr[11:2] == trb_pkg::IDX_LOC_D3_D4) begin
                sel = trb_pkg::SEL_LOC2;
            end else if (addr[11:2] == trb_pkg::IDX_STATUS) begin
                sel = trb_pkg::SEL_STATUS;
            end else if (addr[11:2] == trb_pkg::IDX_SIGN_A_B) begin
                sel = trb_pkg::SEL_SIGN;
            end else if (addr[11:2] == trb_pkg::IDX_INT_STATUS) begin
                sel = trb_pkg::SEL_INT_STATUS;
            end else if (addr[11:2] == trb_pkg::IDX_INT_MASK) begin
                sel = trb_pkg::SEL_INT_MASK;
            end
        end
        return sel;
    endfunction

    // A channel has overflowed once its count reaches the maximum
    function automatic logic reached_max(input logic [2:0] count);
        return count >= trb_pkg::MAX_PEAK_COUNT;
    endfunction

    // ------------------------------------------------------------
    // Result storage
    // ------------------------------------------------------------
    logic [15:0] diag_status;
    logic [15:0] sign_a_b;
    logic [15:0] loc_rd_data;
    logic [3:0] cross_vec;
    logic [3:0] ovf_vec;
    logic [3:0] high_vec;
    logic [47:0] loc_image;

    // Per-channel flags, channel A in bit 0 through channel D in bit 3
    assign cross_vec = {cross_mode_peak_flag_d, cross_mode_peak_flag_c,
                        cross_mode_peak_flag_b, cross_mode_peak_flag_a};
    assign ovf_vec = {reached_max(peak_total_d), reached_max(peak_total_c),
                      reached_max(peak_total_b), reached_max(peak_total_a)};
    assign high_vec = {first_segment_high_cross_d, first_segment_high_cross_c,
                       first_segment_high_cross_b, first_segment_high_cross_a};

    // Word order of the location image follows the register order
    // word 0 in the low bits, word 2 in the high bits
    assign loc_image = {peak_position_chan_d_4, peak_position_chan_d_3,
                        peak_position_chan_d_2, peak_position_chan_d_1,
                        peak_position_chan_d_0, peak_position_chan_c_4};

    // General status word, replaced whole at the end of each run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_status <= trb_pkg::RESULT_RESET;
        end else if (run_done) begin
            diag_status <= 16'h0000;
            diag_status[trb_pkg::STAT_CROSS_LSB +: trb_pkg::CHANS] <= cross_vec;
            diag_status[trb_pkg::STAT_OVF_LSB +: trb_pkg::CHANS] <= ovf_vec;
            diag_status[trb_pkg::STAT_HIGH_LSB +: trb_pkg::CHANS] <= high_vec;
        end
    end

    // Sign bits of channels A and B; upper bits stay zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sign_a_b <= trb_pkg::RESULT_RESET;
        end else if (run_done) begin
            sign_a_b <= 16'h0000;
            sign_a_b[trb_pkg::SIGN_B_LSB +: trb_pkg::PEAKS] <= peak_polarity_chan_b;
            sign_a_b[trb_pkg::SIGN_A_LSB +: trb_pkg::PEAKS] <= peak_polarity_chan_a;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_FETCH,
        RD_RESP
    } trb_rd_state_t;

    trb_rd_state_t rd_state;
    trb_pkg::trb_sel_t rd_sel;
    trb_pkg::trb_sel_t ar_sel;
    logic ar_take;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [1:0] loc_index;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign ar_sel = decode(s_axi_araddr);

    // Location word index straight from the decoded address
    always_comb begin
        unique case (ar_sel)
            trb_pkg::SEL_LOC1: loc_index = 2'h1;
            trb_pkg::SEL_LOC2: loc_index = 2'h2;
            default: loc_index = 2'h0;
        endcase
    end

    // location bytes held in memory, reset to zero
    trb_loc_mem #(
        .WORDS(trb_pkg::LOC_WORDS),
        .WIDTH(trb_pkg::REG_W),
        .IDX_W(trb_pkg::LOC_IDX_W)
    ) u_loc_mem (
        .clk(aclk),
        .rst_n(aresetn),
        .load(run_done),
        .load_data(loc_image),
        .rd_en(ar_take),
        .rd_index(loc_index),
        .rd_data(loc_rd_data)
    );

    // Memory read costs a cycle, so the answer comes two edges after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            rd_sel <= trb_pkg::SEL_NONE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= trb_pkg::RESP_OKAY;
        end else begin
            unique case (rd_state)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        s_axi_arready <= 1'b0;
                        rd_sel <= ar_sel;
                        rd_state <= RD_FETCH;
                    end
                end
                RD_FETCH: begin
                    s_axi_rvalid <= 1'b1;
                    s_axi_rresp <= trb_pkg::RESP_OKAY;
                    s_axi_rdata <= 32'h00000000;
                    unique case (rd_sel)
                        trb_pkg::SEL_LOC0, trb_pkg::SEL_LOC1, trb_pkg::SEL_LOC2: begin
                            s_axi_rdata[15:0] <= loc_rd_data;
                        end
                        trb_pkg::SEL_STATUS: s_axi_rdata[15:0] <= diag_status;
                        trb_pkg::SEL_SIGN: s_axi_rdata[15:0] <= sign_a_b;
                        trb_pkg::SEL_INT_STATUS: s_axi_rdata[3:0] <= int_status;
                        trb_pkg::SEL_INT_MASK: s_axi_rdata[3:0] <= int_mask;
                        trb_pkg::SEL_NONE: s_axi_rresp <= trb_pkg::RESP_SLVERR;
                    endcase
                    rd_state <= RD_RESP;
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic do_write;
    trb_pkg::trb_sel_t wr_sel;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_sel = decode(wr_addr);

    // Address and data may arrive in either order; each is parked until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 12'h000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= trb_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == trb_pkg::SEL_NONE) ? trb_pkg::RESP_SLVERR : trb_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------
    logic [3:0] int_set;
    logic [3:0] int_clr;
    logic [3:0] next_int_status;
    logic [3:0] next_int_mask;

    // Run events; a set in the clearing cycle survives
    always_comb begin
        int_set = 4'h0;
        if (run_done) begin
            int_set[trb_pkg::INT_RUN_DONE] = 1'b1;
            int_set[trb_pkg::INT_CROSS] = |cross_vec;
            int_set[trb_pkg::INT_OVF] = |ovf_vec;
            int_set[trb_pkg::INT_HIGH] = |high_vec;
        end
        int_clr = 4'h0;
        if (do_write && wr_sel == trb_pkg::SEL_INT_STATUS && wr_strb[0]) begin
            int_clr = wr_data[3:0];
        end
        next_int_status = (int_status & ~int_clr) | int_set;
        next_int_mask = int_mask;
        if (do_write && wr_sel == trb_pkg::SEL_INT_MASK && wr_strb[0]) begin
            next_int_mask = wr_data[3:0];
        end
    end

    // Sticky status bits, cleared by writing ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= 4'h0;
        end else begin
            int_status <= next_int_status;
        end
    end

    // Mask steers the interrupt line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_mask <= trb_pkg::INT_MASK_RESET;
        end else begin
            int_mask <= next_int_mask;
        end
    end

    // Registered level output, built from next values so it tracks status without lag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_int_status & next_int_mask);
        end
    end

endmodule

// ---- trb_pkg.sv ----
// Package: register map, field layout and constants of the reflection result bank
package trb_pkg;

    // ------------------------------------------------------------
    // Register word indices and address width
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_LOC_C4_D0 = 10'h197;
    localparam logic [9:0] IDX_LOC_D1_D2 = 10'h198;
    localparam logic [9:0] IDX_LOC_D3_D4 = 10'h199;
    localparam logic [9:0] IDX_STATUS = 10'h1A4;
    localparam logic [9:0] IDX_SIGN_A_B = 10'h1A5;
    localparam logic [9:0] IDX_INT_STATUS = 10'h1B0;
    localparam logic [9:0] IDX_INT_MASK = 10'h1B1;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int LOC_W = 8;
    localparam int REG_W = 16;
    localparam int PEAKS = 5;
    localparam int CHANS = 4;
    localparam int CNT_W = 3;
    localparam int STAT_CROSS_LSB = 8;
    localparam int STAT_OVF_LSB = 4;
    localparam int STAT_HIGH_LSB = 0;
    localparam int SIGN_B_LSB = 5;
    localparam int SIGN_A_LSB = 0;
    localparam int LOC_WORDS = 3;
    localparam int LOC_IDX_W = 2;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [3:0] INT_MASK_RESET = 4'h0;
    localparam logic [2:0] MAX_PEAK_COUNT = 3'h5;

    // Interrupt event bits
    localparam int INT_W = 4;
    localparam int INT_RUN_DONE = 0;
    localparam int INT_CROSS = 1;
    localparam int INT_OVF = 2;
    localparam int INT_HIGH = 3;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_LOC0,
        SEL_LOC1,
        SEL_LOC2,
        SEL_STATUS,
        SEL_SIGN,
        SEL_INT_STATUS,
        SEL_INT_MASK,
        SEL_NONE
    } trb_sel_t;

endpackage

// ---- trb_loc_mem.sv ----
// Small memory holding packed peak location words, loaded in parallel, registered read
`timescale 1ns/1ps
module trb_loc_mem #(
    parameter int WORDS = 3,
    parameter int WIDTH = 16,
    parameter int IDX_W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WORDS*WIDTH-1:0] load_data,
    input wire logic rd_en,
    input wire logic [IDX_W-1:0] rd_index,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [WORDS];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Whole image replaced at once so a read never sees half a run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= '0;
            end
        end else if (load) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= load_data[i*WIDTH +: WIDTH];
            end
        end
    end

    // Registered read port; out of range index reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            if (int'(rd_index) < WORDS) begin
                rd_data <= mem[rd_index];
            end else begin
                rd_data <= '0;
            end
        end
    end

endmodule

// ---- trb_result_bank_assertions.sv ----
// Checker for bus timing, read data shape and interrupt cause of the result bank
`timescale 1ns/1ps
module trb_result_bank_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic run_done,
    input wire logic irq
);
    // ----------------------------------------
    // Clocking and sequences
    // ----------------------------------------
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence aw_w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence r_answer;
        !s_axi_rvalid ##1 s_axi_rvalid;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    rd_latency_a: assert property (ar_take |=> r_answer)
        else $error("read answer not two cycles after address");
    wr_response_a: assert property (aw_w_take |=> !s_axi_awready ##1 (s_axi_bvalid && !s_axi_awready))
        else $error("write response not two cycles after take");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accepted");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accepted");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half of read word not zero");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == trb_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address accepted during pending read");
    reset_state_a: assert property ($rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
        else $error("outputs not idle after reset");
    irq_cause_a: assert property ($rose(irq) |-> $past(run_done) || $rose(s_axi_bvalid))
        else $error("interrupt rose without run or write");
endmodule

bind trb_result_bank trb_result_bank_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_done, .irq);

// ---- testbench.sv ----
// Testbench for the reflection result bank: reset values, runs, writes, errors, interrupt
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    logic aclk, aresetn, run_done, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] peak_position_chan_c_4, peak_position_chan_d_0, peak_position_chan_d_1;
    logic [7:0] peak_position_chan_d_2, peak_position_chan_d_3, peak_position_chan_d_4;
    logic [4:0] peak_polarity_chan_a, peak_polarity_chan_b;
    logic cross_mode_peak_flag_a, cross_mode_peak_flag_b, cross_mode_peak_flag_c, cross_mode_peak_flag_d;
    logic first_segment_high_cross_a, first_segment_high_cross_b;
    logic first_segment_high_cross_c, first_segment_high_cross_d;
    logic [2:0] peak_total_a, peak_total_b, peak_total_c, peak_total_d;
    int num_errors, samples_checked;
    localparam logic [1:0] OK = trb_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = trb_pkg::RESP_SLVERR;
    localparam logic [11:0] A_INT = {trb_pkg::IDX_INT_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {trb_pkg::IDX_INT_MASK, 2'b00};
    logic [11:0] regs [5] = '{{trb_pkg::IDX_LOC_C4_D0, 2'b00}, {trb_pkg::IDX_LOC_D1_D2, 2'b00},
        {trb_pkg::IDX_LOC_D3_D4, 2'b00}, {trb_pkg::IDX_STATUS, 2'b00}, {trb_pkg::IDX_SIGN_A_B, 2'b00}};
    logic [31:0] exp1 [5] = '{32'h0000A211, 32'h0000C433, 32'h0000E655, 32'h00000596, 32'h00000155};

    trb_result_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_done, .peak_position_chan_c_4,
        .peak_position_chan_d_0, .peak_position_chan_d_1, .peak_position_chan_d_2,
        .peak_position_chan_d_3, .peak_position_chan_d_4, .peak_polarity_chan_a, .peak_polarity_chan_b,
        .cross_mode_peak_flag_a, .cross_mode_peak_flag_b, .cross_mode_peak_flag_c,
        .cross_mode_peak_flag_d, .peak_total_a, .peak_total_b, .peak_total_c, .peak_total_d,
        .first_segment_high_cross_a, .first_segment_high_cross_b, .first_segment_high_cross_c,
        .first_segment_high_cross_d, .irq);

    // Free running 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and response handshakes; no cycle count assumed, the watchdog ends a hang
    task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        axi_read(a, rd, rsp);
        check(rd, exp);
        check({30'h0, rsp}, {30'h0, er});
    endtask

    task wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        axi_write(a, d, rsp);
        check({30'h0, rsp}, {30'h0, er});
    endtask

    // Engine result inputs, held until changed
    task engine(input logic [47:0] loc, input logic [9:0] sgn, input logic [3:0] crs, input logic [3:0] hi,
                input logic [11:0] tot);
        @(posedge aclk);
        {peak_position_chan_d_4, peak_position_chan_d_3, peak_position_chan_d_2, peak_position_chan_d_1,
            peak_position_chan_d_0, peak_position_chan_c_4} <= loc;
        {peak_polarity_chan_b, peak_polarity_chan_a} <= sgn;
        {cross_mode_peak_flag_d, cross_mode_peak_flag_c, cross_mode_peak_flag_b, cross_mode_peak_flag_a} <= crs;
        {first_segment_high_cross_d, first_segment_high_cross_c, first_segment_high_cross_b,
            first_segment_high_cross_a} <= hi;
        {peak_total_d, peak_total_c, peak_total_b, peak_total_a} <= tot;
    endtask

    // One-cycle completion pulse, then one edge so registered outputs settle
    task pulse;
        @(posedge aclk) run_done <= 1'b1;
        @(posedge aclk) run_done <= 1'b0;
        @(posedge aclk);
    endtask

    task conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog and main sequence
    // ----------------------------------------
    initial begin
        #40000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        {aresetn, run_done, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        engine(48'h0, 10'h0, 4'h0, 4'h0, 12'h0);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i], 32'h0, OK);
        $display("Test reset values done");
        engine(48'hE655C433A211, 10'h155, 4'h5, 4'h6, 12'hA25);
        pulse();
        foreach (regs[i]) rd_chk(regs[i], exp1[i], OK);
        $display("Test first run done");
        foreach (regs[i]) wr_chk(regs[i], 32'hFFFF, OK);
        foreach (regs[i]) rd_chk(regs[i], exp1[i], OK);
        rd_chk(12'h000, 32'h0, ERR);
        rd_chk(12'h65E, 32'h0, ERR);
        wr_chk(12'h000, 32'hF, ERR);
        $display("Test writes and errors done");
        engine(48'h010203040506, 10'h3E0, 4'h0, 4'h8, 12'hBAD);
        rd_chk(regs[3], 32'h0596, OK);
        pulse();
        rd_chk(regs[0], 32'h0506, OK);
        rd_chk(regs[2], 32'h0102, OK);
        rd_chk(regs[3], 32'h00F8, OK);
        rd_chk(regs[4], 32'h03E0, OK);
        $display("Test second run done");
        rd_chk(A_INT, 32'hF, OK);
        check({31'h0, irq}, 32'h0);
        wr_chk(A_MASK, 32'h1, OK);
        check({31'h0, irq}, 32'h1);
        wr_chk(A_INT, 32'h1, OK);
        rd_chk(A_INT, 32'hE, OK);
        check({31'h0, irq}, 32'h0);
        wr_chk(A_INT, 32'hE, OK);
        pulse();
        rd_chk(A_INT, 32'hD, OK);
        check({31'h0, irq}, 32'h1);
        // Byte strobe zero must leave the mask untouched
        @(posedge aclk) s_axi_wstrb <= 4'h0;
        wr_chk(A_MASK, 32'h0, OK);
        rd_chk(A_MASK, 32'h1, OK);
        check({31'h0, irq}, 32'h1);
        s_axi_wstrb <= 4'hF;
        $display("Test interrupt done");
        @(posedge aclk) aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check({31'h0, irq}, 32'h0);
        rd_chk(A_MASK, 32'h0, OK);
        rd_chk(regs[3], 32'h0, OK);
        $display("Test second reset done");
        conclude();
    end
endmodule
